// File: reset_config_pkg.sv
// Purpose: shared constants and types of the reset-time strap sampler
// Assumes: 32-bit APB, one aligned word per register
// Notes:   offsets are byte addresses
package reset_config_pkg;

    // =========================================================
    // register map
    localparam logic [11:0] OFS_RESET_STATUS = 12'h000;
    localparam logic [11:0] OFS_IRQ_MUX_SEL  = 12'h004;
    localparam logic [11:0] OFS_RESET_CTRL   = 12'h008;

    // =========================================================
    // reset status field positions
    localparam int STAT_BOOT_LSB = 0;
    localparam int STAT_BOOT_MSB = 1;
    localparam int STAT_PULL_BIT = 2;
    localparam int STAT_KIND_LSB = 4;
    localparam int STAT_KIND_MSB = 6;

    // reset control field positions
    localparam int CTRL_GO_BIT   = 0;
    localparam int CTRL_KIND_LSB = 4;
    localparam int CTRL_KIND_MSB = 6;

    // =========================================================
    // reset values
    localparam logic [15:0] IRQ_MUX_SEL_RST = 16'h0000;
    localparam logic [1:0]  BOOT_RST        = 2'h0;
    localparam logic        PULL_RST        = 1'b0;

    // =========================================================
    // boot selection codes, low bit of the pins is the msb
    localparam logic [1:0] BOOT_INT_FLASH = 2'h0;
    localparam logic [1:0] BOOT_DOWNLOAD  = 2'h1;
    localparam logic [1:0] BOOT_EXT_MEM   = 2'h2;
    localparam logic [1:0] BOOT_RESERVED  = 2'h3;

    // =========================================================
    // timing: strap latch lead before reset_output negates
    localparam int PULL_LEAD_CYCLES  = 4;
    localparam int PULSE_CYCLES_DEF  = 64;

    // =========================================================
    // reset sources
    typedef enum logic [2:0] {
        RK_POWER_ON         = 3'h0,
        RK_EXTERNAL         = 3'h1,
        RK_WATCHDOG         = 3'h2,
        RK_SOFTWARE_SYSTEM  = 3'h3,
        RK_DEBUG_PORT       = 3'h4,
        RK_SOFTWARE_EXTERN  = 3'h5
    } reset_kind_t;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_ASSERT
    } rst_state_t;

endpackage : reset_config_pkg

// File: reset_config_pin_sampler.sv
// Purpose: reset-output pulse, boot and pull strap capture, trigger and
//          external interrupt routing
// Assumes: all pin inputs synchronous to pclk, straps stable in pulse
// Notes:   APB slave with zero wait states
//
// Overview of operation
// - The low boot bit alone picks the config word source; download boot needs both bits.
// - The high boot pin is caught during reset_output to set status/mode.
// - Boot code 00 is flash, 01 download, 10 external memory, 11 reserved.
// - Without the external bus the low boot bit always reads as zero.
// - The pull strap is latched four cycles before reset_output negates.
// - The pull value is kept in status, not refreshed on debug/sw-ext resets.
// - Pull value 0 gives weak pull-downs on timer pins, 1 gives pull-ups.
// - Each conversion trigger starts the queue of the same index.
// - The mux select register routes each interrupt pin or its alternate to the unit.
//
// The address map and the APB register port were decided locally.
`timescale 1ns/100ps

module reset_config_pin_sampler
    import reset_config_pkg::*;
#(
    parameter int          PULSE_CYCLES  = PULSE_CYCLES_DEF,
    parameter bit          HAS_EXT_BUS   = 1'b1,
    parameter int          NUM_TRIG      = 4,
    parameter int          NUM_IRQ       = 16
)(
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // reset requests from other sources
    input  wire logic                 reset_req,
    input  wire logic [2:0]           reset_req_kind,
    output logic                      reset_output,
    // strap pins
    input  wire logic                 boot_select_low,
    input  wire logic                 boot_select_high,
    input  wire logic                 pull_dir_strap,
    // boot program selection
    output logic      [1:0]           boot_select_pins,
    output logic                      cfg_word_ext,
    output logic                      boot_download,
    output logic                      boot_ext_mem,
    output logic                      boot_reserved,
    // timer pin pull direction
    output logic                      timer_pull_up,
    output logic                      timer_pull_down,
    // conversion triggers
    input  wire logic [NUM_TRIG-1:0]  conv_trigger_in,
    output logic      [NUM_TRIG-1:0]  conv_queue_start,
    // external interrupts
    input  wire logic [NUM_IRQ-1:0]   irq_pin_n,
    input  wire logic [NUM_IRQ-1:0]   irq_alt_src,
    output logic      [NUM_IRQ-1:0]   irq_to_sys_unit
);

    localparam int CNT_W = $clog2(PULSE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST =
        CNT_W'(PULSE_CYCLES - 1);
    // edge at which the straps are caught, lead cycles before negation
    localparam logic [CNT_W-1:0] CNT_SAMPLE =
        CNT_W'(PULSE_CYCLES - 1 - PULL_LEAD_CYCLES);

    // =========================================================
    // apb decode
    logic        wr_en;
    logic        hit_status;
    logic        hit_mux;
    logic        hit_ctrl;
    logic        sw_go;
    reset_kind_t sw_kind;

    // zero-wait slave keeps the master's access phase to one cycle
    assign pready = 1'b1;
    assign wr_en  = psel & penable & pwrite;

    always_comb
    begin
        hit_status = 1'b0;
        hit_mux    = 1'b0;
        hit_ctrl   = 1'b0;
        if (paddr == OFS_RESET_STATUS)
        begin
            hit_status = 1'b1;
        end
        else if (paddr == OFS_IRQ_MUX_SEL)
        begin
            hit_mux = 1'b1;
        end
        else if (paddr == OFS_RESET_CTRL)
        begin
            hit_ctrl = 1'b1;
        end
    end

    assign pslverr = psel & penable & ~(hit_status | hit_mux | hit_ctrl);
    assign sw_go   = wr_en & hit_ctrl & pwdata[CTRL_GO_BIT];
    assign sw_kind = reset_kind_t'(pwdata[CTRL_KIND_MSB:CTRL_KIND_LSB]);

    // =========================================================
    // reset sequencer
    rst_state_t       state_ff;
    rst_state_t       nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    reset_kind_t      kind_ff;
    reset_kind_t      nxt_kind;
    logic             rst_pulse_ff;
    logic             nxt_rst_pulse;

    always_comb
    begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_kind   = kind_ff;
        nxt_rst_pulse = rst_pulse_ff;
        case (state_ff)
            ST_IDLE:
            begin
                // hardware requests win over a software write
                if (reset_req)
                begin
                    nxt_state  = ST_ASSERT;
                    nxt_kind   = reset_kind_t'(reset_req_kind);
                    nxt_cnt    = '0;
                    nxt_rst_pulse = 1'b1;
                end
                else if (sw_go)
                begin
                    nxt_state  = ST_ASSERT;
                    nxt_kind   = sw_kind;
                    nxt_cnt    = '0;
                    nxt_rst_pulse = 1'b1;
                end
            end
            ST_ASSERT:
            begin
                // requests during the pulse are dropped, not queued
                if (cnt_ff == CNT_LAST)
                begin
                    nxt_state  = ST_IDLE;
                    nxt_rst_pulse = 1'b0;
                end
                else
                begin
                    nxt_cnt = cnt_ff + CNT_W'(1);
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // power-on: the pulse starts straight out of presetn
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff  <= ST_ASSERT;
            cnt_ff    <= '0;
            kind_ff   <= RK_POWER_ON;
            rst_pulse_ff <= 1'b1;
        end
        else
        begin
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            kind_ff   <= nxt_kind;
            rst_pulse_ff <= nxt_rst_pulse;
        end
    end

    assign reset_output = rst_pulse_ff;

    // =========================================================
    // strap capture
    logic       sample_now;
    logic       boot_low_eff;
    logic [1:0] boot_ff;
    logic [1:0] nxt_boot;
    logic       pull_ff;
    logic       nxt_pull;
    logic       refresh_pull;

    assign sample_now   = (state_ff == ST_ASSERT) && (cnt_ff == CNT_SAMPLE);
    assign boot_low_eff = HAS_EXT_BUS ? boot_select_low : 1'b0;
    assign refresh_pull = (kind_ff != RK_DEBUG_PORT) &&
                          (kind_ff != RK_SOFTWARE_EXTERN);

    always_comb
    begin
        nxt_boot = boot_ff;
        nxt_pull = pull_ff;
        if (sample_now)
        begin
            nxt_boot = {boot_low_eff, boot_select_high};
            if (refresh_pull)
            begin
                nxt_pull = pull_dir_strap;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            boot_ff <= BOOT_RST;
            pull_ff <= PULL_RST;
        end
        else
        begin
            boot_ff <= nxt_boot;
            pull_ff <= nxt_pull;
        end
    end

    // =========================================================
    // boot selection and pull direction outputs
    assign boot_select_pins = boot_ff;
    assign cfg_word_ext     = boot_ff[1];
    assign boot_download    = (boot_ff == BOOT_DOWNLOAD);
    assign boot_ext_mem     = (boot_ff == BOOT_EXT_MEM);
    assign boot_reserved    = (boot_ff == BOOT_RESERVED);
    // pulls only take effect once reset_output has negated
    assign timer_pull_up    = ~rst_pulse_ff & pull_ff;
    assign timer_pull_down  = ~rst_pulse_ff & ~pull_ff;

    // =========================================================
    // interrupt mux select register
    logic [NUM_IRQ-1:0] mux_ff;
    logic [NUM_IRQ-1:0] nxt_mux;

    always_comb
    begin
        nxt_mux = mux_ff;
        if (wr_en && hit_mux)
        begin
            nxt_mux = pwdata[NUM_IRQ-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mux_ff <= IRQ_MUX_SEL_RST[NUM_IRQ-1:0];
        end
        else
        begin
            mux_ff <= nxt_mux;
        end
    end

    // =========================================================
    // read data
    // comb from the registers so a zero-wait access phase sees it
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite && hit_status)
        begin
            prdata[STAT_BOOT_MSB:STAT_BOOT_LSB] = boot_ff;
            prdata[STAT_PULL_BIT]               = pull_ff;
            prdata[STAT_KIND_MSB:STAT_KIND_LSB] = kind_ff;
        end
        else if (psel && !pwrite && hit_mux)
        begin
            prdata[NUM_IRQ-1:0] = mux_ff;
        end
    end

    // =========================================================
    // conversion triggers and interrupt routing
    logic [NUM_TRIG-1:0] trig_prev_ff;
    logic [NUM_TRIG-1:0] start_ff;
    logic [NUM_TRIG-1:0] nxt_start;
    logic [NUM_IRQ-1:0]  irq_ff;
    logic [NUM_IRQ-1:0]  nxt_irq;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_TRIG; gi++)
        begin : g_trig
            // one start pulse per rising trigger edge
            assign nxt_start[gi] = conv_trigger_in[gi] &
                                   ~trig_prev_ff[gi];
        end
        for (gi = 0; gi < NUM_IRQ; gi++)
        begin : g_irq
            // pins are active low; unselected lines take the alternate
            assign nxt_irq[gi] = mux_ff[gi] ? ~irq_pin_n[gi]
                                            : irq_alt_src[gi];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trig_prev_ff <= '0;
            start_ff     <= '0;
            irq_ff       <= '0;
        end
        else
        begin
            trig_prev_ff <= conv_trigger_in;
            start_ff     <= nxt_start;
            irq_ff       <= nxt_irq;
        end
    end

    assign conv_queue_start = start_ff;
    assign irq_to_sys_unit  = irq_ff;

endmodule : reset_config_pin_sampler

// File: reset_config_chk.sv
// Purpose: port checks of the reset strap sampler
// Assumes: one pclk domain, bound from the bench top
// Notes:   pulse length taken from the bound instance
`timescale 1ns/100ps
module reset_config_chk
    import reset_config_pkg::*;
#(
    parameter int PULSE_CYCLES  = PULSE_CYCLES_DEF,
    parameter bit HAS_EXT_BUS   = 1'b1,
    parameter int NUM_TRIG      = 4,
    parameter int NUM_IRQ       = 16
)(
    // clock and reset
    input wire logic                pclk,
    input wire logic                presetn,
    // watched pins
    input wire logic                reset_output,
    input wire logic [1:0]          boot_select_pins,
    input wire logic                cfg_word_ext,
    input wire logic                boot_download,
    input wire logic                boot_ext_mem,
    input wire logic                boot_reserved,
    input wire logic                timer_pull_up,
    input wire logic                timer_pull_down,
    input wire logic [NUM_TRIG-1:0] conv_trigger_in,
    input wire logic [NUM_TRIG-1:0] conv_queue_start,
    input wire logic [NUM_IRQ-1:0]  irq_pin_n,
    input wire logic [NUM_IRQ-1:0]  irq_alt_src,
    input wire logic [NUM_IRQ-1:0]  irq_to_sys_unit
);
    // ====================================
    // properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_pulse_end;
        ##PULSE_CYCLES $fell(reset_output);
    endsequence
    // boot pins move at the strap latch, four edges before negation
    sequence s_lead_end;
        reset_output ##PULL_LEAD_CYCLES $fell(reset_output);
    endsequence
    property p_latch_lead;
        $changed(boot_select_pins) |-> s_lead_end;
    endproperty
    a_latch_lead: assert property (p_latch_lead)
        else $error("straps not latched ahead of negation");
    property p_cfg_word;
        cfg_word_ext == boot_select_pins[1];
    endproperty
    a_cfg_word: assert property (p_cfg_word)
        else $error("config word source bit wrong");
    property p_boot_decode;
        {boot_reserved, boot_ext_mem, boot_download} ==
        {boot_select_pins == BOOT_RESERVED,
         boot_select_pins == BOOT_EXT_MEM,
         boot_select_pins == BOOT_DOWNLOAD};
    endproperty
    a_boot_decode: assert property (p_boot_decode)
        else $error("boot decode wrong");
    property p_no_ext_bus;
        !HAS_EXT_BUS |-> !boot_select_pins[1];
    endproperty
    a_no_ext_bus: assert property (p_no_ext_bus)
        else $error("external boot on part without bus");
    // straps only move in or just after a pulse
    property p_boot_hold;
        !reset_output && !$past(reset_output) |-> $stable(boot_select_pins);
    endproperty
    a_boot_hold: assert property (p_boot_hold)
        else $error("boot pins moved outside reset pulse");
    property p_pull_sense;
        !reset_output && !$past(reset_output) |->
        $stable(timer_pull_up) && (timer_pull_up != timer_pull_down);
    endproperty
    a_pull_sense: assert property (p_pull_sense)
        else $error("pull direction wrong");
    property p_rst_len;
        $rose(reset_output) |-> s_pulse_end;
    endproperty
    a_rst_len: assert property (p_rst_len)
        else $error("reset pulse length wrong");
    property p_trig;
        conv_queue_start ==
        ($past(conv_trigger_in) & ~$past(conv_trigger_in, 2));
    endproperty
    a_trig: assert property (p_trig)
        else $error("queue start not from its own trigger");
    // each output bit follows either its pin or its alternate
    property p_irq_route;
        ((irq_to_sys_unit ^ ~$past(irq_pin_n)) &
         (irq_to_sys_unit ^ $past(irq_alt_src))) == '0;
    endproperty
    a_irq_route: assert property (p_irq_route)
        else $error("interrupt routing wrong");
endmodule : reset_config_chk

// File: strap_board_model.sv
// Purpose: board straps for the sampler
// Assumes: wanted levels {low,high,pull} from the bench
// Notes:   new levels pass only while presetn or reset_output is low
`timescale 1ns/100ps
module strap_board_model (
    // control
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       reset_output,
    input  wire logic [2:0] want,
    // strap pins
    output logic            boot_select_low,
    output logic            boot_select_high,
    output logic            pull_dir_strap
);
    // ====================================
    // straps frozen while the pulse runs
    always_ff @(posedge pclk)
    begin
        if (!presetn || !reset_output)
        begin
            {boot_select_low, boot_select_high, pull_dir_strap} <= want;
        end
    end
endmodule : strap_board_model

// File: test_reset_config_pin_sampler.sv
// Purpose: self-checking bench of the strap sampler
// Assumes: zero-wait APB, short reset pulse
// Notes:   straps come from the board model
`timescale 1ns/100ps
module test_reset_config_pin_sampler;
    import reset_config_pkg::*;
    // ====================================
    // signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        reset_req, reset_output, er;
    logic        boot_select_low, boot_select_high, pull_dir_strap;
    logic        cfg_word_ext, boot_download, boot_ext_mem, boot_reserved;
    logic        timer_pull_up, timer_pull_down;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  reset_req_kind, want;
    logic [1:0]  boot_select_pins, boot_nb;
    logic [3:0]  conv_trigger_in, conv_queue_start;
    logic [15:0] irq_pin_n, irq_alt_src, irq_to_sys_unit;
    int          err_count, n_compared;
    reset_config_pin_sampler #(.PULSE_CYCLES(8)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reset_req(reset_req),
        .reset_req_kind(reset_req_kind), .reset_output(reset_output),
        .boot_select_low(boot_select_low), .pull_dir_strap(pull_dir_strap),
        .boot_select_high(boot_select_high), .cfg_word_ext(cfg_word_ext),
        .boot_select_pins(boot_select_pins), .boot_download(boot_download),
        .boot_ext_mem(boot_ext_mem), .boot_reserved(boot_reserved),
        .timer_pull_up(timer_pull_up), .timer_pull_down(timer_pull_down),
        .conv_trigger_in(conv_trigger_in), .irq_pin_n(irq_pin_n),
        .conv_queue_start(conv_queue_start), .irq_alt_src(irq_alt_src),
        .irq_to_sys_unit(irq_to_sys_unit));
    // same straps and bus on a part without the external bus
    reset_config_pin_sampler #(.PULSE_CYCLES(8), .HAS_EXT_BUS(1'b0))
        u_dut_no_bus (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .reset_req(reset_req),
        .reset_req_kind(reset_req_kind), .reset_output(),
        .boot_select_low(boot_select_low), .pull_dir_strap(pull_dir_strap),
        .boot_select_high(boot_select_high), .cfg_word_ext(),
        .boot_select_pins(boot_nb), .boot_download(), .boot_ext_mem(),
        .boot_reserved(), .timer_pull_up(), .timer_pull_down(),
        .conv_trigger_in(conv_trigger_in), .irq_pin_n(irq_pin_n),
        .conv_queue_start(), .irq_alt_src(irq_alt_src),
        .irq_to_sys_unit());
    strap_board_model u_board (
        .pclk(pclk), .presetn(presetn), .reset_output(reset_output),
        .want(want), .boot_select_low(boot_select_low),
        .boot_select_high(boot_select_high), .pull_dir_strap(pull_dir_strap));
    // ====================================
    // tasks
    task close_out;
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task hang;
        err_count++;
        close_out();
    endtask : hang
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
            hang();
    endtask : apb
    // runs one reset pulse, by request line or by control write
    task pulse(input logic [2:0] k, input logic [2:0] w, input logic sw);
        int n;
        want <= w;
        if (sw)
            apb(1'b1, OFS_RESET_CTRL, {25'h0, k, 4'h1});
        else
        begin
            @(posedge pclk);
            reset_req      <= 1'b1;
            reset_req_kind <= k;
            @(posedge pclk);
            reset_req      <= 1'b0;
        end
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (reset_output !== 1'b0 && n < 40);
        if (n >= 40)
            hang();
    endtask : pulse
    task expect_cfg(input logic [1:0] b, input logic p, input logic [2:0] k);
        apb(1'b0, OFS_RESET_STATUS, 32'h0);
        chk(rd, {25'h0, k, 1'b0, p, b});
        chk({30'h0, boot_select_pins}, {30'h0, b});
        chk({30'h0, boot_nb}, {30'h0, 1'b0, b[0]});
        chk({31'h0, cfg_word_ext}, {31'h0, b[1]});
        chk({29'h0, boot_reserved, boot_ext_mem, boot_download},
            {29'h0, b == 2'h3, b == 2'h2, b == 2'h1});
        chk({30'h0, timer_pull_up, timer_pull_down}, {30'h0, p, ~p});
    endtask : expect_cfg
    // ====================================
    // clock and sequence
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, reset_req} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        reset_req_kind = 3'h0;
        want = 3'h5;
        conv_trigger_in = 4'h0;
        irq_pin_n = 16'hFFFF;
        irq_alt_src = 16'h0000;
        err_count = 0;
        n_compared = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        pulse(3'h0, 3'h5, 1'b0);
        expect_cfg(2'h2, 1'b1, 3'h0);
        for (int i = 0; i < 4; i++)
        begin
            pulse(3'h2, {2'(i), 1'b0}, 1'b0);
            expect_cfg(2'(i), 1'b0, 3'h2);
        end
        // pull level kept on debug and software external resets
        pulse(3'h4, 3'h1, 1'b0);
        expect_cfg(2'h0, 1'b0, 3'h4);
        pulse(3'h5, 3'h3, 1'b1);
        expect_cfg(2'h1, 1'b0, 3'h5);
        pulse(3'h3, 3'h3, 1'b1);
        expect_cfg(2'h1, 1'b1, 3'h3);
        apb(1'b1, OFS_RESET_STATUS, 32'hFFFFFFFF);
        expect_cfg(2'h1, 1'b1, 3'h3);
        apb(1'b0, 12'h00C, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, OFS_IRQ_MUX_SEL, 32'h0000F0F0);
        apb(1'b0, OFS_IRQ_MUX_SEL, 32'h0);
        chk(rd, 32'h0000F0F0);
        irq_pin_n   <= 16'h3C3C;
        irq_alt_src <= 16'hA5A5;
        repeat (2) @(posedge pclk);
        chk({16'h0, irq_to_sys_unit},
            {16'h0, (~16'h3C3C & 16'hF0F0) | (16'hA5A5 & ~16'hF0F0)});
        for (int i = 0; i < 4; i++)
        begin
            conv_trigger_in <= 4'(1 << i);
            repeat (2) @(posedge pclk);
            chk({28'h0, conv_queue_start}, {28'h0, 4'(1 << i)});
            @(posedge pclk);
            chk({28'h0, conv_queue_start}, 32'h0);
            conv_trigger_in <= 4'h0;
            @(posedge pclk);
        end
        close_out();
    end
endmodule : test_reset_config_pin_sampler
bind reset_config_pin_sampler reset_config_chk #(
    .PULSE_CYCLES(PULSE_CYCLES), .HAS_EXT_BUS(HAS_EXT_BUS),
    .NUM_TRIG(NUM_TRIG), .NUM_IRQ(NUM_IRQ)
) u_chk (
    .pclk(pclk), .presetn(presetn), .reset_output(reset_output),
    .boot_select_pins(boot_select_pins), .cfg_word_ext(cfg_word_ext),
    .boot_download(boot_download), .boot_ext_mem(boot_ext_mem),
    .boot_reserved(boot_reserved), .timer_pull_up(timer_pull_up),
    .timer_pull_down(timer_pull_down), .conv_trigger_in(conv_trigger_in),
    .conv_queue_start(conv_queue_start), .irq_pin_n(irq_pin_n),
    .irq_alt_src(irq_alt_src), .irq_to_sys_unit(irq_to_sys_unit));
